// ---- rtl/alu_pkg.sv ----
// Shared constants and types for the logic, shift and move datapath
package alu_pkg;

  // ==========================================================
  // Widths and figures
  localparam int WORD_W = 32;
  localparam int AMT_W = 8;
  localparam int IMM_W = 6;
  localparam int WIDE_IMM_W = 16;
  localparam logic [7:0] AMT_WORD = 8'h20;
  localparam logic [31:0] LZC_ALL_ZERO = 32'h0000_0020;

  // ==========================================================
  // Register map and reset values
  localparam int ADDR_W = 8;
  localparam logic [7:0] FLAGS_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;
  localparam logic [7:0] COUNT_OFS = 8'h0c;
  localparam int FLAG_N_POS = 3;
  localparam int FLAG_Z_POS = 2;
  localparam int FLAG_C_POS = 1;
  localparam int FLAG_V_POS = 0;
  localparam int CTRL_EN_POS = 0;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // ==========================================================
  // Operations and shift kinds
  typedef enum logic [4:0] {
    OP_AND = 5'h00, OP_INCLUSIVE_OR = 5'h01, OP_EXCLUSIVE_OR = 5'h02,
    OP_BIT_CLEAR = 5'h03, OP_OR_NOT = 5'h04, OP_ARITH_SHIFT_RIGHT = 5'h05,
    OP_LOGIC_SHIFT_LEFT = 5'h06, OP_LOGIC_SHIFT_RIGHT = 5'h07,
    OP_ROTATE_RIGHT = 5'h08, OP_ROTATE_THROUGH_CARRY = 5'h09,
    OP_LEADING_ZERO_COUNT = 5'h0a, OP_COMPARE = 5'h0b,
    OP_COMPARE_NEGATED = 5'h0c, OP_COPY = 5'h0d, OP_COPY_INVERTED = 5'h0e,
    OP_COPY_WIDE_IMMEDIATE = 5'h0f
  } alu_op_t;

  typedef enum logic [2:0] {
    SH_NONE = 3'h0, SH_ARITH_RIGHT = 3'h1, SH_LOGIC_LEFT = 3'h2, SH_LOGIC_RIGHT = 3'h3,
    SH_ROTATE_RIGHT = 3'h4, SH_THROUGH_CARRY = 3'h5
  } shift_kind_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        valid;
    alu_op_t     op;
    logic        set_flags;
    logic        dest_is_pc;
    logic [31:0] first_operand;
    logic [31:0] second_operand;
    logic        op2_carry_valid;
    logic        op2_carry;
    logic [31:0] shift_source;
    logic [31:0] shift_amount;
    logic [5:0]  shift_imm;
    logic        shift_by_reg;
    shift_kind_t copy_shift;
    logic [15:0] sixteen_bit_immediate;
  } alu_req_t;

  typedef struct packed {
    logic        valid;
    logic        write_dest;
    logic        branch;
    logic [31:0] value;
  } alu_res_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } flags_t;

endpackage

// ---- rtl/barrel_shifter.sv ----
// Combinational 32-bit shifter with carry-out for all shift kinds
`timescale 1ns/1ps
`default_nettype none
module barrel_shifter
  import alu_pkg::*;
(
  input  wire logic [31:0] value,
  input  wire logic [7:0]  amount,
  input  wire shift_kind_t kind,
  input  wire logic        carry_in,
  output logic [31:0]      result,
  output logic             carry_out,
  output logic             carry_update
);

  logic [32:0] left_ext;
  logic [32:0] right_ext;
  logic [32:0] arith_ext;
  logic [7:0]  arith_amt;
  logic [4:0]  rot;

  // Amounts above one word are clamped so sign fill stays correct
  assign arith_amt = (amount > AMT_WORD) ? AMT_WORD : amount;
  assign left_ext = {1'b0, value} << amount[5:0];
  assign right_ext = {value, 1'b0} >> amount[5:0];
  assign arith_ext = 33'($signed({value, 1'b0}) >>> arith_amt[5:0]);
  assign rot = amount[4:0];

  always_comb begin
    result = value;
    carry_out = carry_in;
    carry_update = (amount != 8'h00);
    case (kind)
      SH_LOGIC_LEFT: begin
        if (amount > AMT_WORD) begin
          result = WORD_RESET;
          carry_out = 1'b0;
        end else begin
          result = left_ext[31:0];
          carry_out = left_ext[32];
        end
      end
      SH_LOGIC_RIGHT: begin
        if (amount > AMT_WORD) begin
          result = WORD_RESET;
          carry_out = 1'b0;
        end else begin
          result = right_ext[32:1];
          carry_out = right_ext[0];
        end
      end
      SH_ARITH_RIGHT: begin
        result = arith_ext[32:1];
        carry_out = arith_ext[0];
      end
      SH_ROTATE_RIGHT: begin
        result = (value >> rot) | (value << (6'd32 - {1'b0, rot}));
        carry_out = result[31];
      end
      SH_THROUGH_CARRY: begin
        result = {carry_in, value[31:1]};
        carry_out = value[0];
        carry_update = 1'b1;
      end
      default: begin
        carry_update = 1'b0;
      end
    endcase
    if (amount == 8'h00 && kind != SH_THROUGH_CARRY) begin
      result = value;
      carry_out = carry_in;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/logic_shift_move_alu.sv ----
// Logic, shift, leading-zero, compare and move datapath with flag register
// ==========================================================
// Overview of operation
// - Conjunction, inclusive-or and exclusive-or combine operands bit by bit.
// - Bit clear ANDs first operand with inverted second operand.
// - Or-not ORs first operand with inverted second operand.
// - Flags change only with the set-flags suffix or on a compare; otherwise all hold.
// - Logic and copy ops: N,Z from result, C from shifter, V holds.
// - Register shifts use only the low byte of the amount register.
// - Immediate lengths: right shifts 1-32, left 0-31, rotate 1-31.
// - Rotate-through-carry moves the source right by exactly one bit.
// - Shifts write only the destination; the shift source stays unchanged.
// - Shift flags: N,Z from result, C last bit out, held at zero.
// - Leading-zero count gives 32 for zero and 0 when bit 31 set.
// - Leading-zero count never changes any flag.
// - Compare subtracts, discards the difference and writes no destination.
// - Compare-negated adds, discards the sum and writes no destination.
// - Both compares always update N, Z, C and V.
// - Copy places second operand; immediate forms take 16-bit values.
// - Copy-inverted writes the bitwise NOT of the second operand.
// - Copy with register-shifted operand acts as the matching shift.
// - Copy to program counter clears bit 0 and branches there.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module logic_shift_move_alu
  import alu_pkg::*;
(
  input  wire logic              SYS_CLK,
  input  wire logic              RST,
  input  wire alu_req_t          REQ,
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [31:0]       REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output alu_res_t               RESULT,
  output flags_t                 FLAGS,
  output logic [31:0]            REG_RDATA
);

  // ==========================================================
  // State
  flags_t      flags_reg;
  flags_t      flags_next;
  alu_res_t    res_reg;
  alu_res_t    res_next;
  logic        ctrl_en_reg;
  logic [31:0] count_reg;
  logic [31:0] rdata_reg;

  logic        take;
  logic        sw_flags_wr;
  logic [31:0] op_a;
  logic [31:0] op_b;

  assign take = REQ.valid && ctrl_en_reg;
  assign sw_flags_wr = REG_WR && (REG_ADDR == FLAGS_OFS);
  assign op_a = REQ.first_operand;
  assign op_b = REQ.second_operand;

  // ==========================================================
  // Shifter operand selection
  shift_kind_t sh_kind;
  logic [7:0]  sh_amount;
  logic [31:0] sh_result;
  logic        sh_carry;
  logic        sh_carry_upd;
  logic        is_shift;

  always_comb begin
    case (REQ.op)
      OP_ARITH_SHIFT_RIGHT: sh_kind = SH_ARITH_RIGHT;
      OP_LOGIC_SHIFT_LEFT: sh_kind = SH_LOGIC_LEFT;
      OP_LOGIC_SHIFT_RIGHT: sh_kind = SH_LOGIC_RIGHT;
      OP_ROTATE_RIGHT: sh_kind = SH_ROTATE_RIGHT;
      OP_ROTATE_THROUGH_CARRY: sh_kind = SH_THROUGH_CARRY;
      OP_COPY: sh_kind = REQ.copy_shift;
      default: sh_kind = SH_NONE;
    endcase
  end

  // Only the low byte counts; upper amount bits are ignored
  assign sh_amount = REQ.shift_by_reg ? REQ.shift_amount[7:0]
                                      : {2'b00, REQ.shift_imm};
  assign is_shift = (sh_kind != SH_NONE);

  barrel_shifter u_shifter (
    .value        (REQ.shift_source),
    .amount       (sh_amount),
    .kind         (sh_kind),
    .carry_in     (flags_reg.c),
    .result       (sh_result),
    .carry_out    (sh_carry),
    .carry_update (sh_carry_upd)
  );

  // ==========================================================
  // Leading-zero count
  logic [31:0] lzc;

  always_comb begin
    lzc = LZC_ALL_ZERO;
    for (int i = 0; i < WORD_W; i++) begin
      if (REQ.shift_source[i]) begin
        lzc = 32'(WORD_W - 1 - i);
      end
    end
  end

  // ==========================================================
  // Compare arithmetic
  logic [32:0] sub_ext;
  logic [32:0] add_ext;
  logic        sub_v;
  logic        add_v;

  assign sub_ext = {1'b0, op_a} + {1'b0, ~op_b} + 33'h0_0000_0001;
  assign add_ext = {1'b0, op_a} + {1'b0, op_b};
  assign sub_v = (op_a[31] != op_b[31]) && (sub_ext[31] != op_a[31]);
  assign add_v = (op_a[31] == op_b[31]) && (add_ext[31] != op_a[31]);

  // ==========================================================
  // Result and flag selection
  logic [31:0] value;
  logic        nz_upd;

  always_comb begin
    value = WORD_RESET;
    res_next = '0;
    flags_next = flags_reg;
    nz_upd = 1'b0;
    res_next.valid = take;
    res_next.write_dest = take;
    case (REQ.op)
      OP_AND: value = op_a & op_b;
      OP_INCLUSIVE_OR: value = op_a | op_b;
      OP_EXCLUSIVE_OR: value = op_a ^ op_b;
      OP_BIT_CLEAR: value = op_a & ~op_b;
      OP_OR_NOT: value = op_a | ~op_b;
      OP_ARITH_SHIFT_RIGHT, OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT,
      OP_ROTATE_RIGHT, OP_ROTATE_THROUGH_CARRY: begin
        value = sh_result;
      end
      OP_LEADING_ZERO_COUNT: value = lzc;
      OP_COMPARE, OP_COMPARE_NEGATED: begin
        res_next.write_dest = 1'b0;
      end
      OP_COPY: value = is_shift ? sh_result : op_b;
      OP_COPY_INVERTED: value = ~op_b;
      OP_COPY_WIDE_IMMEDIATE: value = {16'h0000, REQ.sixteen_bit_immediate};
      default: res_next.write_dest = 1'b0;
    endcase

    // A write to the counter branches to the even address
    if (REQ.op == OP_COPY && REQ.dest_is_pc) begin
      value[0] = 1'b0;
      res_next.branch = take;
    end
    res_next.value = value;

    // Flag update per operation class
    case (REQ.op)
      OP_AND, OP_INCLUSIVE_OR, OP_EXCLUSIVE_OR, OP_BIT_CLEAR, OP_OR_NOT,
      OP_COPY_INVERTED, OP_COPY_WIDE_IMMEDIATE: begin
        if (REQ.set_flags) begin
          nz_upd = 1'b1;
          if (REQ.op2_carry_valid) begin
            flags_next.c = REQ.op2_carry;
          end
        end
      end
      OP_COPY: begin
        if (REQ.set_flags) begin
          nz_upd = 1'b1;
          if (is_shift) begin
            if (sh_carry_upd) begin
              flags_next.c = sh_carry;
            end
          end else if (REQ.op2_carry_valid) begin
            flags_next.c = REQ.op2_carry;
          end
        end
      end
      OP_ARITH_SHIFT_RIGHT, OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT,
      OP_ROTATE_RIGHT, OP_ROTATE_THROUGH_CARRY: begin
        if (REQ.set_flags) begin
          nz_upd = 1'b1;
          if (sh_carry_upd) begin
            flags_next.c = sh_carry;
          end
        end
      end
      OP_COMPARE: begin
        flags_next.n = sub_ext[31];
        flags_next.z = (sub_ext[31:0] == WORD_RESET);
        flags_next.c = sub_ext[32];
        flags_next.v = sub_v;
      end
      OP_COMPARE_NEGATED: begin
        flags_next.n = add_ext[31];
        flags_next.z = (add_ext[31:0] == WORD_RESET);
        flags_next.c = add_ext[32];
        flags_next.v = add_v;
      end
      default: flags_next = flags_reg;
    endcase

    if (nz_upd) begin
      flags_next.n = value[31];
      flags_next.z = (value == WORD_RESET);
    end
  end

  // ==========================================================
  // Result register: ready one cycle after the request
  // Value is held between operations so software can read the last result
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      res_reg <= '0;
    end else if (take) begin
      res_reg <= res_next;
    end else begin
      res_reg.valid <= 1'b0;
      res_reg.write_dest <= 1'b0;
      res_reg.branch <= 1'b0;
    end
  end

  // ==========================================================
  // Flags register; the datapath wins over a software write
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      flags_reg <= flags_t'(FLAGS_RESET);
    end else if (take) begin
      flags_reg <= flags_next;
    end else if (sw_flags_wr) begin
      flags_reg.n <= REG_WDATA[FLAG_N_POS];
      flags_reg.z <= REG_WDATA[FLAG_Z_POS];
      flags_reg.c <= REG_WDATA[FLAG_C_POS];
      flags_reg.v <= REG_WDATA[FLAG_V_POS];
    end
  end

  // ==========================================================
  // Control and operation counter
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_en_reg <= CTRL_EN_RESET;
    end else if (REG_WR && REG_ADDR == CTRL_OFS) begin
      ctrl_en_reg <= REG_WDATA[CTRL_EN_POS];
    end
  end

  // Counter wraps silently; software reads it as a progress marker
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      count_reg <= WORD_RESET;
    end else if (REG_WR && REG_ADDR == COUNT_OFS) begin
      count_reg <= REG_WDATA;
    end else if (take) begin
      count_reg <= count_reg + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Register read port, data one cycle after the strobe
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rdata_reg <= WORD_RESET;
    end else if (REG_RD) begin
      case (REG_ADDR)
        FLAGS_OFS: rdata_reg <= {28'h0000000, flags_reg};
        CTRL_OFS: rdata_reg <= {31'h00000000, ctrl_en_reg};
        RESULT_OFS: rdata_reg <= res_reg.value;
        COUNT_OFS: rdata_reg <= count_reg;
        default: rdata_reg <= WORD_RESET;
      endcase
    end else begin
      rdata_reg <= WORD_RESET;
    end
  end

  assign RESULT = res_reg;
  assign FLAGS = flags_reg;
  assign REG_RDATA = rdata_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  logic quiet_flags_op;
  assign quiet_flags_op = take && !sw_flags_wr && !REQ.set_flags
    && REQ.op != OP_COMPARE && REQ.op != OP_COMPARE_NEGATED;

  a_flags_hold_plain: assert property (quiet_flags_op |=> $stable(flags_reg))
    else $error("flags changed without set-flags");

  a_count_flags_hold: assert property (
    take && !sw_flags_wr && REQ.op == OP_LEADING_ZERO_COUNT |=> $stable(flags_reg))
    else $error("leading-zero count changed flags");

  a_logic_v_hold: assert property (
    take && !sw_flags_wr && REQ.op == OP_EXCLUSIVE_OR |=> $stable(flags_reg.v))
    else $error("logic op changed overflow");

  a_and_value: assert property (
    take && REQ.op == OP_AND |=> res_reg.value == ($past(op_a) & $past(op_b)))
    else $error("conjunction result wrong");

  a_clear_value: assert property (
    take && REQ.op == OP_BIT_CLEAR |=> res_reg.value == ($past(op_a) & ~$past(op_b)))
    else $error("bit clear result wrong");

  a_or_not_value: assert property (
    take && REQ.op == OP_OR_NOT |=> res_reg.value == ($past(op_a) | ~$past(op_b)))
    else $error("or-not result wrong");

  a_clz_zero_src: assert property (
    take && REQ.op == OP_LEADING_ZERO_COUNT && REQ.shift_source == WORD_RESET
    |=> res_reg.value == LZC_ALL_ZERO)
    else $error("leading-zero count of zero is not 32");

  a_compare_no_dest: assert property (
    take && (REQ.op == OP_COMPARE || REQ.op == OP_COMPARE_NEGATED)
    |=> res_reg.valid && !res_reg.write_dest)
    else $error("compare wrote a destination");

  a_compare_equal_flags: assert property (
    take && REQ.op == OP_COMPARE && op_a == op_b |=> flags_reg.z && flags_reg.c)
    else $error("equal compare did not set Z and C");

  a_carry_rotate_value: assert property (
    take && REQ.op == OP_ROTATE_THROUGH_CARRY
    |=> res_reg.value == {$past(flags_reg.c), $past(REQ.shift_source[31:1])})
    else $error("rotate-through-carry result wrong");

  a_shift_zero_carry: assert property (
    take && !sw_flags_wr && REQ.op == OP_LOGIC_SHIFT_LEFT && sh_amount == 8'h00
    |=> $stable(flags_reg.c))
    else $error("zero-length shift changed carry");

  a_pc_even_branch: assert property (
    take && REQ.op == OP_COPY && REQ.dest_is_pc |=> res_reg.branch && !res_reg.value[0])
    else $error("copy to counter not even or no branch");

  c_compare_taken: cover property (take && REQ.op == OP_COMPARE ##1 res_reg.valid);
  c_copy_branch: cover property (take && REQ.op == OP_COPY && REQ.dest_is_pc);
  c_big_reg_shift: cover property (take && REQ.shift_by_reg && sh_amount > AMT_WORD);
  c_back_to_back: cover property (take ##1 take ##1 take);

endmodule
`default_nettype wire

// ---- verification/req_source.sv ----
// Model of the decoder and register file that hands requests to the datapath
`timescale 1ns/1ps
`default_nettype none
module req_source
  import alu_pkg::*;
(
  input  wire logic sys_clk,
  output alu_req_t  req
);
  // ==========================================================
  // Request driver
  initial begin
    req = '0;
  end

  // Holds the request over exactly one taking edge, then scrambles the
  // released fields so that no stale operand can pass for a live one
  task automatic issue(input alu_req_t r);
    alu_req_t w;
    alu_req_t idle;
    w = r;
    if (w.dest_is_pc) begin
      w.op = OP_COPY;
      w.copy_shift = SH_NONE;
      w.set_flags = 1'h0;
    end
    w.valid = 1'h1;
    idle = alu_req_t'(~w);
    idle.valid = 1'h0;
    @(posedge sys_clk);
    req <= w;
    @(posedge sys_clk);
    req <= idle;
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the logic, shift and move datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
  import alu_pkg::*;
  // ==========================================================
  // Signals
  logic        sys_clk   = 1'h0;
  logic        rst       = 1'h1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'h0;
  logic        reg_rd    = 1'h0;
  alu_req_t    req;
  alu_res_t    result;
  flags_t      flags;
  logic [31:0] reg_rdata;
  alu_req_t    base;
  int          errors    = 0;
  int          compares  = 0;
  int          taken     = 0;

  always #12.5 sys_clk = ~sys_clk;

  logic_shift_move_alu DUT (
    .SYS_CLK(sys_clk), .RST(rst), .REQ(req), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .RESULT(result), .FLAGS(flags), .REG_RDATA(reg_rdata)
  );
  req_source src (.sys_clk(sys_clk), .req(req));

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_read(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1;
    chk(reg_rdata, e, "register read");
  endtask

  // Bounded wait; running out of cycles when an answer is due ends the run
  task automatic wait_result(input logic want);
    int i;
    for (i = 0; i < 3 && result.valid !== 1'h1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (want && result.valid !== 1'h1) begin
      errors++;
      $display("mismatch at %0t: no result within the wait limit", $time);
      tally_and_finish();
    end
  endtask

  task automatic run(input alu_req_t r, input logic [31:0] ev, input logic [3:0] ef,
                     input logic ewd);
    src.issue(r);
    #1;
    wait_result(1'h1);
    chk(32'(result.valid), 32'h1, "result valid");
    if (!r.dest_is_pc) chk(32'(result.write_dest), 32'(ewd), "write dest");
    chk(32'(result.branch), 32'(r.dest_is_pc), "branch");
    if (ewd) chk(result.value, ev, "value");
    chk(32'(flags), 32'(ef), "flags");
    taken++;
    @(posedge sys_clk);
    #1;
    chk(32'(result.valid), 32'h0, "valid pulse");
    base = '0;
  endtask

  task automatic op(input alu_op_t o, input logic s, input logic [31:0] a, input logic [31:0] b,
                    input logic [31:0] ev, input logic [3:0] ef, input logic ewd);
    alu_req_t r;
    r = base;
    r.op = o;
    r.set_flags = s;
    r.first_operand = a;
    r.second_operand = b;
    run(r, ev, ef, ewd);
  endtask

  // The unused amount source is inverted so that a wrong selection shows
  task automatic sh(input alu_op_t o, input logic byreg, input logic [31:0] sv,
                    input logic [31:0] amt, input logic [31:0] ev, input logic [3:0] ef);
    alu_req_t r;
    r = base;
    r.op = o;
    r.set_flags = 1'h1;
    r.shift_source = sv;
    r.shift_by_reg = byreg;
    r.shift_amount = byreg ? amt : ~amt;
    r.shift_imm = byreg ? ~amt[5:0] : amt[5:0];
    run(r, ev, ef, 1'h1);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    base = '0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'h0;
    bus_read(FLAGS_OFS, 32'h0);
    bus_read(CTRL_OFS, 32'h1);
    bus_read(RESULT_OFS, 32'h0);
    bus_read(COUNT_OFS, 32'h0);
    bus_read(8'h10, 32'h0);
    bus_write(8'h10, 32'hf);
    bus_write(FLAGS_OFS, 32'h3);
    bus_read(FLAGS_OFS, 32'h3);
    op(OP_AND, 1, 32'hf0f0_00ff, 32'h0ff0_0f0f, 32'h00f0_000f, 4'h3, 1);
    base.op2_carry_valid = 1'h1;
    op(OP_INCLUSIVE_OR, 1, 32'h8000_0000, 32'h1, 32'h8000_0001, 4'h9, 1);
    op(OP_EXCLUSIVE_OR, 1, 32'h5a5a_5a5a, 32'h5a5a_5a5a, 32'h0, 4'h5, 1);
    op(OP_BIT_CLEAR, 0, 32'hffff_ffff, 32'hff, 32'hffff_ff00, 4'h5, 1);
    op(OP_OR_NOT, 1, 32'h0, 32'hffff_fffe, 32'h1, 4'h1, 1);
    sh(OP_LOGIC_SHIFT_LEFT, 0, 32'h8000_0001, 32'h0, 32'h8000_0001, 4'h9);
    sh(OP_LOGIC_SHIFT_RIGHT, 0, 32'h8000_0000, 32'h20, 32'h0, 4'h7);
    sh(OP_ARITH_SHIFT_RIGHT, 0, 32'h8000_0000, 32'h20, 32'hffff_ffff, 4'hb);
    sh(OP_ROTATE_RIGHT, 0, 32'h12, 32'h4, 32'h2000_0001, 4'h1);
    sh(OP_ROTATE_RIGHT, 1, 32'h3, 32'h121, 32'h8000_0001, 4'hb);
    sh(OP_LOGIC_SHIFT_RIGHT, 1, 32'h6, 32'h100, 32'h6, 4'h3);
    sh(OP_ROTATE_THROUGH_CARRY, 0, 32'h2, 32'h1, 32'h8000_0001, 4'h9);
    sh(OP_LOGIC_SHIFT_LEFT, 1, 32'h1, 32'h104, 32'h10, 4'h1);
    sh(OP_LEADING_ZERO_COUNT, 0, 32'h0, 32'h0, 32'h20, 4'h1);
    sh(OP_LEADING_ZERO_COUNT, 0, 32'h8000_0000, 32'h0, 32'h0, 4'h1);
    sh(OP_LEADING_ZERO_COUNT, 0, 32'h0001_0000, 32'h0, 32'hf, 4'h1);
    op(OP_COMPARE, 0, 32'h5, 32'h5, 32'h0, 4'h6, 0);
    op(OP_COMPARE, 0, 32'h8000_0000, 32'h1, 32'h0, 4'h3, 0);
    op(OP_COMPARE_NEGATED, 0, 32'hffff_ffff, 32'h1, 32'h0, 4'h6, 0);
    op(OP_COMPARE_NEGATED, 0, 32'h7fff_ffff, 32'h1, 32'h0, 4'h9, 0);
    base.op2_carry_valid = 1'h1;
    base.op2_carry = 1'h1;
    op(OP_COPY, 1, 32'h0, 32'h1234_5678, 32'h1234_5678, 4'h3, 1);
    op(OP_COPY_INVERTED, 1, 32'h0, 32'hf, 32'hffff_fff0, 4'hb, 1);
    base.sixteen_bit_immediate = 16'hffff;
    op(OP_COPY_WIDE_IMMEDIATE, 1, 32'h0, 32'h0, 32'h0000_ffff, 4'h3, 1);
    base.copy_shift = SH_LOGIC_RIGHT;
    sh(OP_COPY, 1, 32'h8000_0000, 32'h8, 32'h0080_0000, 4'h1);
    base.dest_is_pc = 1'h1;
    op(OP_COPY, 0, 32'h0, 32'h1235, 32'h1234, 4'h1, 1);
    bus_read(RESULT_OFS, 32'h1234);
    bus_read(COUNT_OFS, 32'(taken));
    // Disabled datapath must ignore a request outright
    bus_write(CTRL_OFS, 32'h0);
    bus_read(CTRL_OFS, 32'h0);
    base.op = OP_EXCLUSIVE_OR;
    base.set_flags = 1'h1;
    base.first_operand = 32'h8000_0000;
    src.issue(base);
    #1;
    wait_result(1'h0);
    chk(32'(result.valid), 32'h0, "refused request");
    chk(32'(flags), 32'h1, "flags after refusal");
    base = '0;
    bus_write(CTRL_OFS, 32'h1);
    bus_read(COUNT_OFS, 32'(taken));
    tally_and_finish();
  end
endmodule
`default_nettype wire
